/* design/dte_map.svh */
// Purpose: Offsets, field positions and reset values of the transfer engine
// Assumes: Descriptors are four aligned longwords in on-chip memory
// Notes: Included by its bare name; definitions only
`ifndef DTE_MAP_SVH
`define DTE_MAP_SVH

// Descriptor word indices, each a longword after the descriptor address
`define DSC_CTRL 2'h0
`define DSC_SRC 2'h1
`define DSC_DST 2'h2
`define DSC_CNT 2'h3
`define DSC_LAST 2'h3
// Byte distance between two chained descriptors
`define DSC_STRIDE 32'h0000_0010

// Control word fields
`define CF_MODE_HI 31
`define CF_MODE_LO 30
`define CF_UNIT_HI 29
`define CF_UNIT_LO 28
`define CF_SRC_INC 27
`define CF_DST_INC 26
`define CF_RPT_DST 25
`define CF_IRQ_EACH 24
`define CF_IRQ_DONE 23
`define CF_CHAIN 22
`define CF_CHAIN_ZERO 21
`define CF_FULL_ADDR 20
`define CF_FWD_ACT 19
`define CF_RELOAD_HI 15
`define CF_RELOAD_LO 8

// Vector base register fields and reset value
`define VBR_LOW_W 10
`define VBR_HIGH_W 22
`define VBR_LOW_RESET 10'h000
`define VBR_HIGH_RESET 22'h00_0000

// Highest address bit kept in short-address mode before sign extension
`define SHORT_SIGN_BIT 23

`endif

/* design/dte_pkg.sv */
// Purpose: Types shared by the transfer engine files
// Assumes: Nothing beyond the map header
// Notes: Mode and unit codes follow the control word encoding
package dte_pkg;
	typedef enum logic [1:0] {
		MODE_NORMAL, MODE_REPEAT, MODE_BLOCK, MODE_RSVD
	} mode_e;
	typedef enum logic [1:0] {
		UNIT_BYTE, UNIT_WORD, UNIT_LONG, UNIT_RSVD
	} unit_e;
	typedef enum logic [2:0] {
		ST_IDLE, ST_VEC, ST_DSC, ST_XRD, ST_XWR, ST_WB, ST_NEXT
	} state_e;
endpackage

/* design/addr_step.sv */
// Purpose: Next transfer address for one side of the engine
// Assumes: Unit code 0 byte, 1 word, 2 longword; 3 treated as longword
// Notes: Short mode sign-extends from the short sign bit
`timescale 1ns/1ps
`default_nettype none
`include "dte_map.svh"

module addr_step #(
	parameter int AW = 32
) (
	input wire logic [AW-1:0] cur,
	input wire logic [AW-1:0] start,
	input wire logic [1:0] unit,
	input wire logic inc,
	input wire logic reload,
	input wire logic fullAddr,
	output logic [AW-1:0] nxt
);
	logic [AW-1:0] stepV;
	logic [AW-1:0] sum;

	// Step by unit size, or fall back to the start address
	always_comb begin
		stepV = (unit == 2'h3) ? AW'(4) : (AW'(1) << unit);
		sum = reload ? start : (inc ? cur + stepV : cur);
		if (fullAddr) begin
			nxt = sum;
		end else begin
			nxt = {{(AW - `SHORT_SIGN_BIT - 1){sum[`SHORT_SIGN_BIT]}},
				sum[`SHORT_SIGN_BIT:0]};
		end
	end
endmodule

`default_nettype wire

/* design/xfer_buffer.sv */
// Purpose: Two-entry buffer between the read and write halves of a transfer
// Assumes: Single clock, asynchronous active-high reset
// Notes: Output data come straight from storage flops
`timescale 1ns/1ps
`default_nettype none

module xfer_buffer #(
	parameter int W = 32
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic inValid,
	output logic inReady,
	input wire logic [W-1:0] inData,
	output logic outValid,
	input wire logic outReady,
	output logic [W-1:0] outData
);
	logic [W-1:0] slotQ [2];
	logic wrPtrQ;
	logic rdPtrQ;
	logic [1:0] fillQ;
	logic push;
	logic pop;

	assign inReady = (fillQ != 2'h2);
	assign outValid = (fillQ != 2'h0);
	assign outData = slotQ[rdPtrQ];
	assign push = inValid && inReady;
	assign pop = outValid && outReady;

	// Storage needs no reset; fill count guards every read
	always_ff @(posedge mclk) begin
		if (push) begin
			slotQ[wrPtrQ] <= inData;
		end
	end

	// Pointers and fill level
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			wrPtrQ <= 1'b0;
			rdPtrQ <= 1'b0;
			fillQ <= 2'h0;
		end else begin
			if (push) begin
				wrPtrQ <= ~wrPtrQ;
			end
			if (pop) begin
				rdPtrQ <= ~rdPtrQ;
			end
			fillQ <= fillQ + {1'b0, push} - {1'b0, pop};
		end
	end
endmodule

`default_nettype wire

/* design/data_transfer_engine.sv */
// Purpose: Interrupt-activated data transfer engine on the internal bus
// Assumes: Interrupt unit and memory bus run on mclk; no synchronisers
// Notes: Descriptor is four longwords; vector entry is one longword
`timescale 1ns/1ps
`default_nettype none
`include "dte_map.svh"

// How it works
// - Normal mode: one unit per activation
// - Repeat mode reloads start address after size
// - Repeat size counts up to 256 units
// - Block mode moves a whole block per activation
// - Block length 1 to 256 units
// - Activating source selects its own channel
// - Chaining runs several channels per activation
// - Chain always, or only when count zero
// - Short addresses sign-extend into 16 MB
// - Full mode uses whole 32-bit addresses
// - Activating interrupt may pass to CPU
// - Optional CPU request after each unit
// - Optional CPU request when count expires
// - Read skip reuses held descriptor
// - Fixed addresses are not written back
// - Module stop halts new activations
// - Vector base has 10-bit and 22-bit fields
// - Transfers use engine's own synchronous bus
module data_transfer_engine #(
	parameter int SRC_W = 7,
	parameter int CNT_W = 16
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic actReq,
	input wire logic [SRC_W-1:0] actSource,
	output logic actAck,
	input wire logic moduleStop,
	input wire logic readSkipEn,
	input wire logic vbrWe,
	input wire logic [31:0] vbrWdata,
	output logic [31:0] vbrRdata,
	output logic memReq,
	output logic memWe,
	output logic [1:0] memSize,
	output logic [31:0] memAddr,
	output logic [31:0] memWdata,
	input wire logic memGnt,
	input wire logic memRvalid,
	input wire logic [31:0] memRdata,
	output logic cpuIrq,
	output logic [SRC_W-1:0] cpuIrqSrc,
	output logic busy,
	output logic stopped
);
	dte_pkg::state_e stateQ;
	logic [1:0] idxQ;
	logic [`VBR_LOW_W-1:0] vbrLowQ;
	logic [`VBR_HIGH_W-1:0] vbrHighQ;
	logic [SRC_W-1:0] curSrcQ;
	logic [SRC_W-1:0] lastSrcQ;
	logic heldOkQ;
	logic chainedQ;
	logic expiredQ;
	logic [31:0] descAddrQ;
	logic [31:0] ctrlQ;
	logic [31:0] srcAddrQ;
	logic [31:0] dstAddrQ;
	logic [31:0] srcStartQ;
	logic [31:0] dstStartQ;
	logic [CNT_W-1:0] cntQ;
	logic [7:0] blkLeftQ;
	logic memReqQ;
	logic memWeQ;
	logic waitRdQ;
	logic [31:0] memAddrQ;
	logic [31:0] memWdataQ;
	logic [1:0] memSizeQ;
	logic irqQ;
	logic [SRC_W-1:0] irqSrcQ;
	logic stoppedQ;

	dte_pkg::mode_e mode;
	logic [1:0] unit;
	logic srcInc;
	logic dstInc;
	logic rptDst;
	logic fullAddr;
	logic [7:0] reload8;
	logic accept;
	logic skipRead;
	logic wbSkip;
	logic busState;
	logic launch;
	logic launchWe;
	logic [31:0] launchAddr;
	logic [31:0] launchData;
	logic [1:0] launchSize;
	logic rdDone;
	logic wrDone;
	logic xferDone;
	logic rptLast;
	logic blkLast;
	logic sideReload;
	logic countExpire;
	logic chainGo;
	logic loadSrc;
	logic loadDst;
	logic [31:0] srcNext;
	logic [31:0] dstNext;
	logic [7:0] rptSpan;
	logic [31:0] rptBack;
	logic [31:0] srcBase;
	logic [31:0] dstBase;
	logic bufInReady;
	logic bufOutValid;
	logic [31:0] bufOutData;

	// Control word decode
	assign mode = dte_pkg::mode_e'(ctrlQ[`CF_MODE_HI:`CF_MODE_LO]);
	assign unit = ctrlQ[`CF_UNIT_HI:`CF_UNIT_LO];
	assign srcInc = ctrlQ[`CF_SRC_INC];
	assign dstInc = ctrlQ[`CF_DST_INC];
	assign rptDst = ctrlQ[`CF_RPT_DST];
	assign fullAddr = ctrlQ[`CF_FULL_ADDR];
	assign reload8 = ctrlQ[`CF_RELOAD_HI:`CF_RELOAD_LO];

	// A stopped module leaves requests pending at the interrupt unit
	assign accept = (stateQ == dte_pkg::ST_IDLE) && actReq && !moduleStop;
	assign actAck = accept;
	// Held copy is only trusted for the same source and no chain since
	assign skipRead = readSkipEn && heldOkQ && (actSource == lastSrcQ);
	assign wbSkip = (stateQ == dte_pkg::ST_WB) &&
		(((idxQ == `DSC_SRC) && !srcInc) ||
		((idxQ == `DSC_DST) && !dstInc));

	// Bus answer detection
	assign rdDone = waitRdQ && memRvalid;
	assign wrDone = memReqQ && memWeQ && memGnt;
	assign xferDone = wrDone && (stateQ == dte_pkg::ST_XWR);

	// Counter outcomes of the unit now being written
	assign rptLast = (cntQ[7:0] == 8'h01);
	assign blkLast = (blkLeftQ == 8'h01);
	assign sideReload = ((mode == dte_pkg::MODE_REPEAT) && rptLast) ||
		((mode == dte_pkg::MODE_BLOCK) && blkLast);
	assign countExpire = (cntQ == CNT_W'(1)) &&
		((mode == dte_pkg::MODE_NORMAL) ||
		((mode == dte_pkg::MODE_BLOCK) && blkLast));
	assign chainGo = ctrlQ[`CF_CHAIN] &&
		(!ctrlQ[`CF_CHAIN_ZERO] || (cntQ == CNT_W'(0)));

	// Launch a bus cycle once the previous one is answered
	assign busState = (stateQ == dte_pkg::ST_VEC) ||
		(stateQ == dte_pkg::ST_DSC) || (stateQ == dte_pkg::ST_XRD) ||
		(stateQ == dte_pkg::ST_XWR) || (stateQ == dte_pkg::ST_WB);
	assign launch = busState && !memReqQ && !waitRdQ && !wbSkip &&
		((stateQ != dte_pkg::ST_XRD) || bufInReady) &&
		((stateQ != dte_pkg::ST_XWR) || bufOutValid);
	assign launchWe = (stateQ == dte_pkg::ST_XWR) ||
		(stateQ == dte_pkg::ST_WB);

	// Address, data and size of the cycle about to start
	always_comb begin
		launchSize = 2'h2;
		launchData = bufOutData;
		unique case (stateQ)
			dte_pkg::ST_VEC: begin
				launchAddr = {vbrHighQ, vbrLowQ} +
					32'({curSrcQ, 2'h0});
			end
			dte_pkg::ST_DSC: begin
				launchAddr = descAddrQ + 32'({idxQ, 2'h0});
			end
			dte_pkg::ST_XRD: begin
				launchAddr = srcAddrQ;
				launchSize = unit;
			end
			dte_pkg::ST_XWR: begin
				launchAddr = dstAddrQ;
				launchSize = unit;
			end
			dte_pkg::ST_WB: begin
				launchAddr = descAddrQ + 32'({idxQ, 2'h0});
				if (idxQ == `DSC_SRC) begin
					launchData = srcAddrQ;
				end else if (idxQ == `DSC_DST) begin
					launchData = dstAddrQ;
				end else begin
					launchData = 32'(cntQ);
				end
			end
			dte_pkg::ST_IDLE, dte_pkg::ST_NEXT: begin
				launchAddr = descAddrQ;
			end
			default: begin
				launchAddr = descAddrQ;
			end
		endcase
	end

	// Address arithmetic for both sides
	assign loadSrc = (stateQ == dte_pkg::ST_DSC) && (idxQ == `DSC_SRC);
	assign loadDst = (stateQ == dte_pkg::ST_DSC) && (idxQ == `DSC_DST);
	// Repeat mode re-reads the descriptor on every activation that does not skip the read, so the
	// start is found by stepping back over the area, not from the copy
	assign rptSpan = reload8 - 8'h01;
	assign rptBack = 32'(rptSpan) << ((unit == 2'h3) ? 2'h2 : unit);
	assign srcBase = (mode == dte_pkg::MODE_REPEAT) ?
		srcAddrQ - rptBack : srcStartQ;
	assign dstBase = (mode == dte_pkg::MODE_REPEAT) ?
		dstAddrQ - rptBack : dstStartQ;

	addr_step #(.AW(32)) srcStep (
		.cur(loadSrc ? memRdata : srcAddrQ),
		.start(srcBase),
		.unit(unit),
		.inc(srcInc && !loadSrc),
		.reload(sideReload && !rptDst && !loadSrc),
		.fullAddr(fullAddr),
		.nxt(srcNext)
	);

	addr_step #(.AW(32)) dstStep (
		.cur(loadDst ? memRdata : dstAddrQ),
		.start(dstBase),
		.unit(unit),
		.inc(dstInc && !loadDst),
		.reload(sideReload && rptDst && !loadDst),
		.fullAddr(fullAddr),
		.nxt(dstNext)
	);

	// Read data wait here so a slow write side never drops a unit
	xfer_buffer #(.W(32)) unitBuf (
		.mclk(mclk),
		.rst(rst),
		.inValid(rdDone && (stateQ == dte_pkg::ST_XRD)),
		.inReady(bufInReady),
		.inData(memRdata),
		.outValid(bufOutValid),
		.outReady(launch && (stateQ == dte_pkg::ST_XWR)),
		.outData(bufOutData)
	);

	// Sequencer
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			stateQ <= dte_pkg::ST_IDLE;
			idxQ <= `DSC_CTRL;
		end else begin
			unique case (stateQ)
				dte_pkg::ST_IDLE: begin
					if (accept) begin
						stateQ <= skipRead ? dte_pkg::ST_XRD : dte_pkg::ST_VEC;
					end
				end
				dte_pkg::ST_VEC: begin
					if (rdDone) begin
						stateQ <= dte_pkg::ST_DSC;
						idxQ <= `DSC_CTRL;
					end
				end
				dte_pkg::ST_DSC: begin
					if (rdDone) begin
						if (idxQ == `DSC_LAST) begin
							stateQ <= dte_pkg::ST_XRD;
						end
						idxQ <= idxQ + 2'h1;
					end
				end
				dte_pkg::ST_XRD: begin
					if (rdDone) begin
						stateQ <= dte_pkg::ST_XWR;
					end
				end
				dte_pkg::ST_XWR: begin
					if (wrDone) begin
						// Block mode stays until its last unit
						if ((mode == dte_pkg::MODE_BLOCK) && !blkLast) begin
							stateQ <= dte_pkg::ST_XRD;
						end else begin
							stateQ <= dte_pkg::ST_WB;
							idxQ <= `DSC_SRC;
						end
					end
				end
				dte_pkg::ST_WB: begin
					if (wbSkip || wrDone) begin
						if (idxQ == `DSC_LAST) begin
							stateQ <= dte_pkg::ST_NEXT;
						end
						idxQ <= idxQ + 2'h1;
					end
				end
				dte_pkg::ST_NEXT: begin
					if (chainGo) begin
						stateQ <= dte_pkg::ST_DSC;
						idxQ <= `DSC_CTRL;
					end else begin
						stateQ <= dte_pkg::ST_IDLE;
					end
				end
				default: begin
					stateQ <= dte_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// Descriptor working copy, updated as units move
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			descAddrQ <= 32'h0000_0000;
			ctrlQ <= 32'h0000_0000;
			srcAddrQ <= 32'h0000_0000;
			dstAddrQ <= 32'h0000_0000;
			srcStartQ <= 32'h0000_0000;
			dstStartQ <= 32'h0000_0000;
			cntQ <= '0;
			blkLeftQ <= 8'h00;
		end else begin
			if ((stateQ == dte_pkg::ST_VEC) && rdDone) begin
				descAddrQ <= memRdata;
			end
			if ((stateQ == dte_pkg::ST_NEXT) && chainGo) begin
				descAddrQ <= descAddrQ + `DSC_STRIDE;
			end
			if ((stateQ == dte_pkg::ST_DSC) && rdDone) begin
				unique case (idxQ)
					`DSC_CTRL: ctrlQ <= memRdata;
					`DSC_SRC: begin
						srcAddrQ <= srcNext;
						srcStartQ <= srcNext;
					end
					`DSC_DST: begin
						dstAddrQ <= dstNext;
						dstStartQ <= dstNext;
					end
					`DSC_CNT: begin
						cntQ <= memRdata[CNT_W-1:0];
						blkLeftQ <= reload8;
					end
				endcase
			end
			if (accept && skipRead) begin
				blkLeftQ <= reload8;
			end
			if (xferDone) begin
				srcAddrQ <= srcNext;
				dstAddrQ <= dstNext;
				unique case (mode)
					dte_pkg::MODE_REPEAT: begin
						// Reload 0 stands for 256 units
						cntQ[7:0] <= rptLast ? reload8 : cntQ[7:0] - 8'h01;
					end
					dte_pkg::MODE_BLOCK: begin
						blkLeftQ <= blkLast ? reload8 : blkLeftQ - 8'h01;
						if (blkLast) begin
							cntQ <= cntQ - CNT_W'(1);
						end
					end
					default: begin
						cntQ <= cntQ - CNT_W'(1);
					end
				endcase
			end
		end
	end

	// Bus master outputs held until granted
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			memReqQ <= 1'b0;
			memWeQ <= 1'b0;
			waitRdQ <= 1'b0;
			memAddrQ <= 32'h0000_0000;
			memWdataQ <= 32'h0000_0000;
			memSizeQ <= 2'h2;
		end else begin
			if (launch) begin
				memReqQ <= 1'b1;
				memWeQ <= launchWe;
				memAddrQ <= launchAddr;
				memWdataQ <= launchData;
				memSizeQ <= launchSize;
			end else if (memReqQ && memGnt) begin
				memReqQ <= 1'b0;
			end
			if (memReqQ && memGnt && !memWeQ) begin
				waitRdQ <= 1'b1;
			end else if (memRvalid) begin
				waitRdQ <= 1'b0;
			end
		end
	end

	// Activation bookkeeping for read skip and count expiry
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			curSrcQ <= '0;
			lastSrcQ <= '0;
			heldOkQ <= 1'b0;
			chainedQ <= 1'b0;
			expiredQ <= 1'b0;
		end else begin
			if (accept) begin
				curSrcQ <= actSource;
				chainedQ <= 1'b0;
				expiredQ <= 1'b0;
				heldOkQ <= 1'b0;
			end
			if (xferDone && countExpire) begin
				expiredQ <= 1'b1;
			end
			if (stateQ == dte_pkg::ST_NEXT) begin
				if (chainGo) begin
					chainedQ <= 1'b1;
				end else begin
					lastSrcQ <= curSrcQ;
					// A new vector base also spoils the held copy
					heldOkQ <= !chainedQ && !vbrWe;
				end
			end else if (vbrWe) begin
				heldOkQ <= 1'b0;
			end
		end
	end

	// CPU interrupt requests, one pulse per event cycle
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			irqQ <= 1'b0;
			irqSrcQ <= '0;
		end else begin
			irqQ <= (xferDone && ctrlQ[`CF_IRQ_EACH]) ||
				((stateQ == dte_pkg::ST_NEXT) && !chainGo &&
				(ctrlQ[`CF_FWD_ACT] ||
				(ctrlQ[`CF_IRQ_DONE] && expiredQ)));
			irqSrcQ <= curSrcQ;
		end
	end

	// Vector base register and stop status
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			vbrLowQ <= `VBR_LOW_RESET;
			vbrHighQ <= `VBR_HIGH_RESET;
			stoppedQ <= 1'b0;
		end else begin
			if (vbrWe) begin
				vbrLowQ <= vbrWdata[`VBR_LOW_W-1:0];
				vbrHighQ <= vbrWdata[31:`VBR_LOW_W];
			end
			stoppedQ <= moduleStop && (stateQ == dte_pkg::ST_IDLE);
		end
	end

	assign vbrRdata = {vbrHighQ, vbrLowQ};
	assign memReq = memReqQ;
	assign memWe = memWeQ;
	assign memAddr = memAddrQ;
	assign memWdata = memWdataQ;
	assign memSize = memSizeQ;
	assign cpuIrq = irqQ;
	assign cpuIrqSrc = irqSrcQ;
	assign busy = (stateQ != dte_pkg::ST_IDLE);
	assign stopped = stoppedQ;
endmodule

`default_nettype wire

/* tb/dte_mem_model.sv */
// Purpose: On-chip memory on the engine's internal bus, byte addressed
// Assumes: 4 KB array, little-endian lanes, addresses wrap at 4 KB
// Notes: A stall input from the bench delays grants and read data alike
`timescale 1ns/1ps
`default_nettype none

module dte_mem_model (
	input wire logic mclk,
	input wire logic rst,
	input wire logic stall,
	input wire logic memReq,
	input wire logic memWe,
	input wire logic [1:0] memSize,
	input wire logic [31:0] memAddr,
	input wire logic [31:0] memWdata,
	output logic memGnt,
	output logic memRvalid,
	output logic [31:0] memRdata
);
	logic [7:0] mem [0:4095];
	logic pendQ;
	logic [11:0] aQ;
	logic [31:0] noiseQ;
	// One access at a time; a read holds the bus until its data return
	assign memGnt = memReq && !stall && !pendQ;
	assign memRvalid = pendQ && !stall;
	// Outside a valid beat the lines wander, so no stale word can pass
	assign memRdata = memRvalid ? {mem[aQ + 12'h003], mem[aQ + 12'h002],
		mem[aQ + 12'h001], mem[aQ]} : noiseQ;
	// Accesses land on the edge of their grant
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			pendQ <= 1'h0;
			noiseQ <= 32'h5A5A_0F0F;
		end else begin
			noiseQ <= {noiseQ[30:0], ~noiseQ[31]};
			if (memRvalid)
				pendQ <= 1'h0;
			if (memGnt && !memWe) begin
				pendQ <= 1'h1;
				aQ <= memAddr[11:0];
			end
			if (memGnt && memWe) begin
				mem[memAddr[11:0]] <= memWdata[7:0];
				if (memSize != 2'h0)
					mem[memAddr[11:0] + 12'h001] <= memWdata[15:8];
				if (memSize[1]) begin
					mem[memAddr[11:0] + 12'h002] <= memWdata[23:16];
					mem[memAddr[11:0] + 12'h003] <= memWdata[31:24];
				end
			end
		end
	end
endmodule
`default_nettype wire

/* tb/data_transfer_engine_checker.sv */
// Purpose: Port-level assertions on the transfer engine
// Assumes: One clock domain, reset active high
// Notes: Attached by bind at the foot of this file
`timescale 1ns/1ps
`default_nettype none

module data_transfer_engine_checker #(
	parameter int SRC_W = 7,
	parameter int CNT_W = 16
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic actReq,
	input wire logic [SRC_W-1:0] actSource,
	input wire logic actAck,
	input wire logic moduleStop,
	input wire logic readSkipEn,
	input wire logic busy,
	input wire logic stopped,
	input wire logic vbrWe,
	input wire logic [31:0] vbrWdata,
	input wire logic [31:0] vbrRdata,
	input wire logic memReq,
	input wire logic memWe,
	input wire logic [31:0] memAddr,
	input wire logic memGnt,
	input wire logic cpuIrq,
	input wire logic [SRC_W-1:0] cpuIrqSrc
);
	logic [SRC_W-1:0] srcQ;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	// Source of the activation in service, for the interrupt tag
	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			srcQ <= '0;
		else if (actAck)
			srcQ <= actSource;
	end
	a_ack_when_idle: assert property (actAck ==
		(actReq && !busy && !moduleStop))
		else $error("acceptance does not match idle request");
	// The request is registered, so it shows two cycles after the ack
	a_vector_fetch: assert property (actAck && !readSkipEn |-> ##2
		memReq && !memWe && memAddr == $past(vbrRdata, 2) +
		32'({$past(actSource, 2), 2'h0}))
		else $error("vector read address wrong");
	a_request_stands: assert property (memReq && !memGnt |=> memReq &&
		$stable(memAddr) && $stable(memWe))
		else $error("bus request changed before grant");
	a_request_drops: assert property (memReq && memGnt |=> !memReq)
		else $error("bus request held after grant");
	a_idle_quiet: assert property (!busy |-> !memReq)
		else $error("bus request while idle");
	a_stop_flag: assert property (moduleStop && !busy |=> stopped)
		else $error("stop flag missing");
	a_base_update: assert property (vbrWe |=> vbrRdata == $past(vbrWdata))
		else $error("vector base not updated");
	a_irq_source: assert property (cpuIrq |-> cpuIrqSrc == srcQ)
		else $error("interrupt source wrong");
endmodule

bind data_transfer_engine data_transfer_engine_checker #(.SRC_W(SRC_W),
	.CNT_W(CNT_W)) i_data_transfer_engine_checker (.mclk(mclk), .rst(rst),
	.actReq(actReq), .actSource(actSource), .actAck(actAck),
	.moduleStop(moduleStop), .readSkipEn(readSkipEn), .busy(busy),
	.stopped(stopped), .vbrWe(vbrWe), .vbrWdata(vbrWdata),
	.vbrRdata(vbrRdata), .memReq(memReq),
	.memWe(memWe), .memAddr(memAddr), .memGnt(memGnt), .cpuIrq(cpuIrq),
	.cpuIrqSrc(cpuIrqSrc));
`default_nettype wire

/* tb/interrupt_driven_data_transfer_test.sv */
// Purpose: Self-checking bench for the interrupt-activated transfer engine
// Assumes: Vector table at 0x400, descriptors and data in model memory
// Notes: Bus stalls come at random every cycle from a fixed seed
`timescale 1ns/1ps
`default_nettype none
`include "dte_map.svh"

module interrupt_driven_data_transfer_test;
	localparam logic [31:0] VB = 32'h0000_0400, D0 = 32'h0000_0100,
		SI = 32'h1 << `CF_SRC_INC, DI = 32'h1 << `CF_DST_INC,
		RD = 32'h1 << `CF_RPT_DST, IE = 32'h1 << `CF_IRQ_EACH,
		IX = 32'h1 << `CF_IRQ_DONE, CH = 32'h1 << `CF_CHAIN,
		CZ = 32'h1 << `CF_CHAIN_ZERO, FA = 32'h1 << `CF_FULL_ADDR,
		FW = 32'h1 << `CF_FWD_ACT;
	logic mclk = 1'h0;
	logic rst = 1'h1;
	logic actReq = 1'h0;
	logic [6:0] actSource = 7'h00;
	logic moduleStop = 1'h0;
	logic readSkipEn = 1'h0;
	logic vbrWe = 1'h0;
	logic [31:0] vbrWdata = 32'h0000_0000;
	logic stall = 1'h0;
	logic actAck, memReq, memWe, memGnt, memRvalid, cpuIrq, busy, stopped;
	logic [1:0] memSize;
	logic [31:0] vbrRdata, memAddr, memWdata, memRdata, firstWr, watch, r;
	logic [6:0] cpuIrqSrc, irqSrc, rs;
	int err_count = 0, total_checks = 0, nRd, nWr, nIrq, wrHit, n1, k;
	int cyc = 0;
	int seed = 32'h6edd;
	int sz[3] = '{1, 3, 256};

	data_transfer_engine #(.SRC_W(7), .CNT_W(16)) i_data_transfer_engine (
		.mclk(mclk), .rst(rst), .actReq(actReq), .actSource(actSource),
		.actAck(actAck), .moduleStop(moduleStop), .readSkipEn(readSkipEn),
		.vbrWe(vbrWe), .vbrWdata(vbrWdata), .vbrRdata(vbrRdata),
		.memReq(memReq), .memWe(memWe), .memSize(memSize),
		.memAddr(memAddr), .memWdata(memWdata), .memGnt(memGnt),
		.memRvalid(memRvalid), .memRdata(memRdata), .cpuIrq(cpuIrq),
		.cpuIrqSrc(cpuIrqSrc), .busy(busy), .stopped(stopped));
	dte_mem_model i_dte_mem_model (.mclk(mclk), .rst(rst), .stall(stall),
		.memReq(memReq), .memWe(memWe), .memSize(memSize),
		.memAddr(memAddr), .memWdata(memWdata), .memGnt(memGnt),
		.memRvalid(memRvalid), .memRdata(memRdata));

	// Clock and a random bus stall so the engine meets slow answers
	always #4 mclk = ~mclk;
	always @(posedge mclk) stall <= ($random(seed) & 3) == 0;
	// Bus and interrupt monitor; also cuts a hang short
	always @(posedge mclk) begin
		cyc++;
		if (memGnt && memWe) begin
			if (nWr == 0)
				firstWr = memAddr;
			nWr++;
			wrHit += (memAddr == watch);
		end
		nRd += (memGnt && !memWe);
		if (cpuIrq) begin
			nIrq++;
			irqSrc = cpuIrqSrc;
		end
		if (cyc == 60000) begin
			err_count++;
			test_done();
		end
	end

	task test_done;
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task put(input logic [31:0] a, input logic [31:0] d);
		for (int i = 0; i < 4; i++)
			i_dte_mem_model.mem[a[11:0] + i] = d[8*i +: 8];
	endtask
	function automatic logic [7:0] mb(input logic [31:0] a);
		return i_dte_mem_model.mem[a[11:0]];
	endfunction
	function automatic logic [31:0] get(input logic [31:0] a);
		return {mb(a + 3), mb(a + 2), mb(a + 1), mb(a)};
	endfunction
	function automatic logic [31:0] cnt;
		return get(D0 + 12) & 32'h0000_FFFF;
	endfunction
	// Lanes that a unit of each size really carries
	function automatic logic [31:0] msk(input int u);
		return u == 0 ? 32'h0000_00FF : u == 1 ? 32'h0000_FFFF : 32'hFFFF_FFFF;
	endfunction
	function automatic logic [31:0] ctl(input int m, input int u,
		input logic [31:0] f);
		return {m[1:0], u[1:0], 28'h000_0000} | f;
	endfunction
	task dsc(input logic [6:0] s, input logic [31:0] c, sa, da, n);
		put(VB + 32'(s) * 4, D0);
		put(D0, c);
		put(D0 + 4, sa);
		put(D0 + 8, da);
		put(D0 + 12, n);
	endtask
	task vbr(input logic [31:0] d);
		@(posedge mclk);
		vbrWe <= 1'h1;
		vbrWdata <= d;
		@(posedge mclk);
		vbrWe <= 1'h0;
		@(negedge mclk);
	endtask
	// One activation: request until taken, then wait out the service
	task act(input logic [6:0] s);
		nRd = 0;
		nWr = 0;
		nIrq = 0;
		wrHit = 0;
		@(posedge mclk);
		actReq <= 1'h1;
		actSource <= s;
		for (k = 0; k < 100 && actAck !== 1'h1; k++) @(negedge mclk);
		@(posedge mclk);
		actReq <= 1'h0;
		@(negedge mclk);
		for (k = 0; k < 6000 && busy !== 1'h0; k++) @(negedge mclk);
		chk(k < 6000, 1);
		repeat (3) @(posedge mclk);
	endtask

	initial begin
		watch = 32'hFFFF_FFFF;
		repeat (5) @(posedge mclk);
		rst <= 1'h0;
		@(negedge mclk);
		chk(vbrRdata, {`VBR_HIGH_RESET, `VBR_LOW_RESET});
		r = $random(seed);
		vbr(r);
		chk(vbrRdata, r);
		vbr(VB);
		$display("vector base done");
		for (int u = 0; u < 3; u++) begin
			r = $random(seed);
			put(32'h600, r);
			put(32'h700, 32'h0000_0000);
			dsc(7'(u + 1), ctl(0, u, SI | DI | (u == 2 ? FW : IE)),
				32'h600, 32'h700, 5);
			act(7'(u + 1));
			chk(get(32'h700), r & msk(u));
			chk(get(D0 + 4), 32'h600 + (32'h1 << u));
			chk(get(D0 + 8), 32'h700 + (32'h1 << u));
			chk(cnt(), 4);
			chk(nIrq, 1);
			chk(irqSrc, u + 1);
		end
		$display("normal mode done");
		foreach (sz[j]) begin
			for (int i = 0; i < 260; i++) begin
				i_dte_mem_model.mem[12'h800 + i] = 8'($random(seed));
				i_dte_mem_model.mem[12'hA00 + i] = 8'hEE;
			end
			dsc(9, ctl(2, 0, SI | DI | IX | (32'(sz[j] % 256) << 8)),
				32'h800, 32'hA00, 1);
			act(9);
			for (int i = 0; i < 257; i++)
				chk(mb(32'hA00 + i), i < sz[j] ? mb(32'h800 + i) : 8'hEE);
			chk(cnt(), 0);
			chk(nIrq, 1);
		end
		$display("block mode done");
		dsc(12, ctl(1, 0, SI | DI | RD), 32'h800, 32'hA00, 0);
		for (int i = 0; i < 257; i++) begin
			act(12);
			chk(firstWr, 32'hA00 + i % 256);
		end
		$display("repeat mode done");
		readSkipEn <= 1'h1;
		// Above the repeat test's source, so no stale held copy is reused
		rs = 7'(13 + {$random(seed)} % 72);
		r = $random(seed);
		put(32'h604, r);
		dsc(rs, ctl(0, 2, SI | DI), 32'h600, 32'h700, 5);
		act(rs);
		n1 = nRd;
		act(rs);
		chk(nRd < n1, 1);
		chk(get(32'h704), r);
		chk(cnt(), 3);
		readSkipEn <= 1'h0;
		$display("read skip done");
		for (int f = 0; f < 2; f++) begin
			watch = D0 + 4 + 4 * f;
			dsc(21, ctl(0, 2, f ? SI : DI), 32'h600, 32'h700, 5);
			act(21);
			chk(wrHit, 0);
			chk(nWr, 3);
		end
		watch = 32'hFFFF_FFFF;
		$display("write-back skip done");
		for (int c = 0; c < 3; c++) begin
			dsc(30, ctl(0, 2, SI | DI | CH | (c ? CZ : 0)), 32'h600,
				32'h700, 5 - 2 * c);
			put(D0 + 16, ctl(0, 2, SI | DI));
			put(D0 + 20, 32'h640);
			put(D0 + 24, 32'h740);
			put(D0 + 28, 9);
			act(30);
			chk(get(D0 + 28) & 32'h0000_FFFF, c == 1 ? 9 : 8);
		end
		$display("chain done");
		for (int f = 0; f < 2; f++) begin
			dsc(40, ctl(0, 2, SI | DI | (f ? FA : 0)), 32'h600,
				32'h0080_0000, 5);
			act(40);
			chk(firstWr, f ? 32'h0080_0000 : 32'hFF80_0000);
		end
		$display("address modes done");
		dsc(41, ctl(0, 2, SI | DI), 32'h600, 32'h700, 5);
		@(posedge mclk);
		moduleStop <= 1'h1;
		repeat (3) @(posedge mclk);
		actReq <= 1'h1;
		actSource <= 7'h29;
		n1 = 0;
		repeat (10) begin
			@(negedge mclk);
			n1 += actAck;
		end
		chk(stopped, 1);
		chk(n1, 0);
		@(posedge mclk);
		moduleStop <= 1'h0;
		actReq <= 1'h0;
		act(41);
		chk(stopped, 0);
		chk(cnt(), 4);
		$display("module stop done");
		test_done();
	end
endmodule
`default_nettype wire
